// file: verilog/irq_ctrl_pkg.sv
// Constants for the four-level nested interrupt controller
package irq_ctrl_pkg;
  // ---------------------------------------------------------------
  // Special-function register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_ENABLE_MASK = 8'ha8;
  localparam logic [7:0] ADDR_PRIO_LOWER = 8'hb8;
  localparam logic [7:0] ADDR_PRIO_UPPER = 8'hb7;
  localparam logic [7:0] RESET_ENABLE_MASK = 8'h00;
  localparam logic [7:0] RESET_PRIO = 8'h00;
  // ---------------------------------------------------------------
  // Field positions: bit 7 global enable, bits 6..0 per source
  // ---------------------------------------------------------------
  localparam int BIT_GLOBAL = 7;
  localparam int BIT_EXT0 = 0;
  localparam int BIT_TMR0 = 1;
  localparam int BIT_EXT1 = 2;
  localparam int BIT_TMR1 = 3;
  localparam int BIT_SER = 4;
  localparam int BIT_TMR2 = 5;
  localparam int BIT_PCA = 6;
  localparam int NUM_SOURCES = 7;
  // ---------------------------------------------------------------
  // Vector addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] VEC_EXT0 = 8'h03;
  localparam logic [7:0] VEC_TMR0 = 8'h0b;
  localparam logic [7:0] VEC_EXT1 = 8'h13;
  localparam logic [7:0] VEC_TMR1 = 8'h1b;
  localparam logic [7:0] VEC_SER = 8'h23;
  localparam logic [7:0] VEC_TMR2 = 8'h2b;
  localparam logic [7:0] VEC_PCA = 8'h33;
endpackage

// file: verilog/irq_select.sv
// Level and polling-order arbiter for pending interrupt sources
`timescale 1ns/10ps
`default_nettype none
module irq_select #(
  parameter int NSRC = 7
) (
  // Per-source inputs
  input wire logic [NSRC-1:0] pending_i,
  input wire logic [NSRC-1:0] prio_lower_i,
  input wire logic [NSRC-1:0] prio_upper_i,
  // Winner
  output logic found_o,
  output logic [2:0] index_o,
  output logic [1:0] level_o
);
  // Polling order: ext0, tmr0, ext1, tmr1, counter array, serial, tmr2
  localparam int POLL_LEN = 7;
  localparam int POLL [POLL_LEN] = '{0, 1, 2, 3, 6, 4, 5};

  always_comb begin
    found_o = 1'b0;
    index_o = 3'h0;
    level_o = 2'h0;
    for (int i = 0; i < POLL_LEN; i++) begin
      if (POLL[i] < NSRC) begin
        if (pending_i[POLL[i]]) begin
          if (!found_o || {prio_upper_i[POLL[i]], prio_lower_i[POLL[i]]} > level_o) begin
            found_o = 1'b1;
            index_o = 3'(POLL[i]);
            level_o = {prio_upper_i[POLL[i]], prio_lower_i[POLL[i]]};
          end
        end
      end
    end
  end
endmodule // irq_select
`default_nettype wire

// file: verilog/irq_controller.sv
// Four-level nested vectored interrupt controller for an 8-bit core
// Functional notes
// - Level is priority-upper bit over priority-lower bit; 11 highest, 00 lowest.
// - Enable, priority-lower and priority-upper registers control interrupts.
// - Priority-upper register sits at address b7, bit-aligned with priority-lower.
// - Accept request only if no equal or higher level in service.
// - Equal or lower requests wait until current service completes.
// - Higher level preempts; in-service levels kept as nesting stack.
// - Seven sources; same-level ties follow fixed polling order.
// - Without counter array, only six sources; its path is absent.
// - Each source vectors to its fixed address.
// - Vectoring clears timer 0/1 flags and edge-mode external flags only.
`timescale 1ns/10ps
`default_nettype none
module irq_controller #(
  parameter bit HAS_PCA = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Special-function register access from the core
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  // Request flags from peripherals (same clock)
  input wire logic ext0_request_flag_i,
  input wire logic ext0_edge_mode_i,
  input wire logic timer0_overflow_flag_i,
  input wire logic ext1_request_flag_i,
  input wire logic ext1_edge_mode_i,
  input wire logic timer1_overflow_flag_i,
  input wire logic serial_flag_i,
  input wire logic timer2_flag_i,
  input wire logic counter_array_flag_i,
  // Hardware flag clears, one-cycle pulses on vectoring
  output logic ext0_flag_clear_o,
  output logic timer0_flag_clear_o,
  output logic ext1_flag_clear_o,
  output logic timer1_flag_clear_o,
  // Core handshake
  output logic irq_req_o,
  output logic [7:0] irq_vector_o,
  input wire logic irq_ack_i,
  input wire logic irq_return_i,
  // Status
  output logic [3:0] in_service_o
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  localparam int NSRC = irq_ctrl_pkg::NUM_SOURCES;
  localparam logic [7:0] IMPL_MASK = HAS_PCA ? 8'hff : 8'hbf;

  logic [7:0] interrupt_enable_mask;
  logic [7:0] interrupt_priority_lower;
  logic [7:0] interrupt_priority_upper;
  logic [3:0] in_service;
  logic [NSRC-1:0] raw_flags;
  logic [NSRC-1:0] pending;
  logic found;
  logic [2:0] win_index;
  logic [1:0] win_level;
  logic [3:0] next_in_service;
  logic accept;
  logic [7:0] vector;
  logic [2:0] taken_index;

  function automatic logic [7:0] vector_of(input logic [2:0] idx);
    case (idx)
      3'h0: vector_of = irq_ctrl_pkg::VEC_EXT0;
      3'h1: vector_of = irq_ctrl_pkg::VEC_TMR0;
      3'h2: vector_of = irq_ctrl_pkg::VEC_EXT1;
      3'h3: vector_of = irq_ctrl_pkg::VEC_TMR1;
      3'h4: vector_of = irq_ctrl_pkg::VEC_SER;
      3'h5: vector_of = irq_ctrl_pkg::VEC_TMR2;
      default: vector_of = irq_ctrl_pkg::VEC_PCA;
    endcase
  endfunction

  // Highest set bit of the in-service stack as its level plus one; zero when the stack is empty
  function automatic logic [2:0] top_level(input logic [3:0] stack);
    top_level = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (stack[i]) begin
        top_level = 3'(i + 1);
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // three control registers
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      interrupt_enable_mask <= irq_ctrl_pkg::RESET_ENABLE_MASK;
    end else if (sfr_wr_i && sfr_addr_i == irq_ctrl_pkg::ADDR_ENABLE_MASK) begin
      interrupt_enable_mask <= sfr_wdata_i & IMPL_MASK;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      interrupt_priority_lower <= irq_ctrl_pkg::RESET_PRIO;
    end else if (sfr_wr_i && sfr_addr_i == irq_ctrl_pkg::ADDR_PRIO_LOWER) begin
      interrupt_priority_lower <= sfr_wdata_i & IMPL_MASK & 8'h7f;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      interrupt_priority_upper <= irq_ctrl_pkg::RESET_PRIO;
    end else if (sfr_wr_i && sfr_addr_i == irq_ctrl_pkg::ADDR_PRIO_UPPER) begin
      interrupt_priority_upper <= sfr_wdata_i & IMPL_MASK & 8'h7f;
    end
  end

  // Read mux; unmapped addresses return zero and no hit
  always_comb begin
    sfr_rdata_o = 8'h00;
    sfr_hit_o = 1'b1;
    if (sfr_addr_i == irq_ctrl_pkg::ADDR_ENABLE_MASK) begin
      sfr_rdata_o = interrupt_enable_mask;
    end else if (sfr_addr_i == irq_ctrl_pkg::ADDR_PRIO_LOWER) begin
      sfr_rdata_o = interrupt_priority_lower;
    end else if (sfr_addr_i == irq_ctrl_pkg::ADDR_PRIO_UPPER) begin
      sfr_rdata_o = interrupt_priority_upper;
    end else begin
      sfr_hit_o = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Request gating and arbitration
  // ---------------------------------------------------------------
  // source bit positions
  always_comb begin
    raw_flags = '0;
    raw_flags[irq_ctrl_pkg::BIT_EXT0] = ext0_request_flag_i;
    raw_flags[irq_ctrl_pkg::BIT_TMR0] = timer0_overflow_flag_i;
    raw_flags[irq_ctrl_pkg::BIT_EXT1] = ext1_request_flag_i;
    raw_flags[irq_ctrl_pkg::BIT_TMR1] = timer1_overflow_flag_i;
    raw_flags[irq_ctrl_pkg::BIT_SER] = serial_flag_i;
    raw_flags[irq_ctrl_pkg::BIT_TMR2] = timer2_flag_i;
    raw_flags[irq_ctrl_pkg::BIT_PCA] = counter_array_flag_i & HAS_PCA;
  end

  assign pending = raw_flags & interrupt_enable_mask[NSRC-1:0]
                   & {NSRC{interrupt_enable_mask[irq_ctrl_pkg::BIT_GLOBAL]}};

  irq_select #(
    .NSRC(NSRC)
  ) u_select (
    .pending_i(pending),
    .prio_lower_i(interrupt_priority_lower[NSRC-1:0]),
    .prio_upper_i(interrupt_priority_upper[NSRC-1:0]),
    .found_o(found),
    .index_o(win_index),
    .level_o(win_level)
  );

  assign irq_req_o = found && ({1'b0, win_level} + 3'h1 > top_level(in_service));
  assign accept = irq_req_o && irq_ack_i;

  // ---------------------------------------------------------------
  // Nesting stack
  // ---------------------------------------------------------------
  // preempt and resume
  always_comb begin
    next_in_service = in_service;
    if (irq_return_i) begin
      // Return pops the most recent, which is always the highest level
      for (int i = 0; i < 4; i++) begin
        if (3'(i + 1) == top_level(in_service)) begin
          next_in_service[i] = 1'b0;
        end
      end
    end
    if (accept) begin
      next_in_service[win_level] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      in_service <= 4'h0;
    end else begin
      in_service <= next_in_service;
    end
  end

  assign in_service_o = in_service;

  // ---------------------------------------------------------------
  // Vector and hardware flag clears
  // ---------------------------------------------------------------
  // fixed vectors
  assign vector = vector_of(win_index);
  assign taken_index = win_index;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_vector_o <= 8'h00;
    end else if (accept) begin
      irq_vector_o <= vector;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext0_flag_clear_o <= 1'b0;
      timer0_flag_clear_o <= 1'b0;
      ext1_flag_clear_o <= 1'b0;
      timer1_flag_clear_o <= 1'b0;
    end else begin
      ext0_flag_clear_o <= accept && taken_index == 3'(irq_ctrl_pkg::BIT_EXT0)
                           && ext0_edge_mode_i;
      timer0_flag_clear_o <= accept && taken_index == 3'(irq_ctrl_pkg::BIT_TMR0);
      ext1_flag_clear_o <= accept && taken_index == 3'(irq_ctrl_pkg::BIT_EXT1)
                           && ext1_edge_mode_i;
      timer1_flag_clear_o <= accept && taken_index == 3'(irq_ctrl_pkg::BIT_TMR1);
    end
  end
endmodule // irq_controller
`default_nettype wire

// file: verif/irq_ctrl_props.sv
// Assertion checker on the interrupt controller ports
`timescale 1ns/10ps
`default_nettype none
module irq_ctrl_props #(
  parameter bit HAS_PCA = 1'b1
) (
  // Clock, reset and register port
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic sfr_hit_o,
  // Flag clears and core handshake
  input wire logic ext0_edge_mode_i,
  input wire logic ext1_edge_mode_i,
  input wire logic ext0_flag_clear_o,
  input wire logic timer0_flag_clear_o,
  input wire logic ext1_flag_clear_o,
  input wire logic timer1_flag_clear_o,
  input wire logic irq_req_o,
  input wire logic [7:0] irq_vector_o,
  input wire logic irq_ack_i,
  input wire logic irq_return_i,
  input wire logic [3:0] in_service_o
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  a_hit_decode:
    assert property (sfr_hit_o == (sfr_addr_i inside {8'ha8, 8'hb8, 8'hb7})) else $error("hit");
  a_upper_readback:
    assert property (sfr_wr_i && sfr_addr_i == 8'hb7 |=> sfr_addr_i != 8'hb7 ||
      sfr_rdata_o == ($past(sfr_wdata_i) & (HAS_PCA ? 8'h7f : 8'h3f))) else $error("upper");
  a_global_mask:
    assert property (sfr_wr_i && sfr_addr_i == 8'ha8 && !sfr_wdata_i[7] |=> !irq_req_o)
      else $error("global mask");
  a_top_blocks:
    assert property (in_service_o[3] |-> !irq_req_o) else $error("level 3 preempted");
  a_push_level:
    assert property (irq_req_o && irq_ack_i && !irq_return_i |=>
      $countones(in_service_o) == $countones($past(in_service_o)) + 1) else $error("push");
  a_pop_level:
    assert property (irq_return_i && !irq_ack_i && in_service_o != 4'h0 |=>
      $countones(in_service_o) + 1 == $countones($past(in_service_o))) else $error("pop");
  a_t0_vector:
    assert property (timer0_flag_clear_o |-> irq_vector_o == 8'h0b &&
      $past(irq_req_o && irq_ack_i)) else $error("timer0 clear");
  a_t1_vector:
    assert property (timer1_flag_clear_o |-> irq_vector_o == 8'h1b) else $error("timer1 clear");
  a_ext0_edge:
    assert property (ext0_flag_clear_o |-> irq_vector_o == 8'h03 && $past(ext0_edge_mode_i))
      else $error("ext0 clear");
  a_ext1_edge:
    assert property (ext1_flag_clear_o |-> irq_vector_o == 8'h13 && $past(ext1_edge_mode_i))
      else $error("ext1 clear");
  a_clear_pulse:
    assert property (timer0_flag_clear_o |=> !timer0_flag_clear_o) else $error("pulse");
endmodule // irq_ctrl_props
`default_nettype wire

// file: verif/irq_source_model.sv
// Peripheral request flags facing the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module irq_source_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Bench set, software clear, controller clears (tmr1, ext1, tmr0, ext0)
  input wire logic [6:0] set_i,
  input wire logic [6:0] sw_clear_i,
  input wire logic [3:0] hw_clear_i,
  // Flags in enable-bit order
  output logic [6:0] flag_o
);
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_o <= 7'h00;
    end else begin
      flag_o <= (flag_o | set_i) & ~sw_clear_i & ~{3'h0, hw_clear_i};
    end
  end
endmodule // irq_source_model
`default_nettype wire

// file: verif/four_level_irq_controller_test.sv
// Self-checking bench for the nested interrupt controller
`timescale 1ns/10ps
`default_nettype none
module four_level_irq_controller_test;
  logic clk_sys_i = 0, rstn_i = 0, sfr_wr_i = 0, irq_ack_i = 0, irq_return_i = 0;
  logic ext0_edge_mode_i = 1, ext1_edge_mode_i = 1, sfr_hit_o, irq_req_o;
  logic ext0_flag_clear_o, timer0_flag_clear_o, ext1_flag_clear_o, timer1_flag_clear_o;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, irq_vector_o, clr;
  logic [6:0] set_src = 7'h00, sw_clr = 7'h00, flag;
  logic [3:0] in_service_o;
  logic [7:0] rdata_six;
  int n_mismatch = 0, samples_checked = 0;
  typedef struct packed {logic [7:0] vec; logic [7:0] clr;} row_t;
  row_t rows [7] = '{'{8'h03, 8'h01}, '{8'h0b, 8'h02}, '{8'h13, 8'h04}, '{8'h1b, 8'h08},
    '{8'h23, 8'h00}, '{8'h2b, 8'h00}, '{8'h33, 8'h00}};
  assign clr = {4'h0, timer1_flag_clear_o, ext1_flag_clear_o, timer0_flag_clear_o,
    ext0_flag_clear_o};
  always #20 clk_sys_i = ~clk_sys_i;
  irq_controller #(.HAS_PCA(1'b1)) i_irq_controller (.clk_sys_i, .rstn_i, .sfr_addr_i,
    .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o, .sfr_hit_o, .ext0_request_flag_i(flag[0]),
    .ext0_edge_mode_i, .timer0_overflow_flag_i(flag[1]), .ext1_request_flag_i(flag[2]),
    .ext1_edge_mode_i, .timer1_overflow_flag_i(flag[3]), .serial_flag_i(flag[4]),
    .timer2_flag_i(flag[5]), .counter_array_flag_i(flag[6]), .ext0_flag_clear_o,
    .timer0_flag_clear_o, .ext1_flag_clear_o, .timer1_flag_clear_o, .irq_req_o,
    .irq_vector_o, .irq_ack_i, .irq_return_i, .in_service_o);
  // Six-source variant shares the register port; only its read data is compared
  irq_controller #(.HAS_PCA(1'b0)) i_irq_controller_six (.clk_sys_i, .rstn_i, .sfr_addr_i,
    .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o(rdata_six), .sfr_hit_o(), .ext0_request_flag_i(flag[0]),
    .ext0_edge_mode_i, .timer0_overflow_flag_i(flag[1]), .ext1_request_flag_i(flag[2]),
    .ext1_edge_mode_i, .timer1_overflow_flag_i(flag[3]), .serial_flag_i(flag[4]),
    .timer2_flag_i(flag[5]), .counter_array_flag_i(flag[6]), .ext0_flag_clear_o(),
    .timer0_flag_clear_o(), .ext1_flag_clear_o(), .timer1_flag_clear_o(), .irq_req_o(),
    .irq_vector_o(), .irq_ack_i(1'b0), .irq_return_i(1'b0), .in_service_o());
  irq_source_model i_irq_source_model (.clk_sys_i, .rstn_i, .set_i(set_src),
    .sw_clear_i(sw_clr), .hw_clear_i(clr[3:0]), .flag_o(flag));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge clk_sys_i);
    sfr_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys_i);
    sfr_addr_i = a;
    #1 chk(sfr_rdata_o, exp);
  endtask
  task automatic raise(input logic [6:0] m);
    @(negedge clk_sys_i);
    set_src = m;
    @(negedge clk_sys_i);
    set_src = 7'h00;
  endtask
  // Ack is held one edge only, so one accept per call
  task automatic serve();
    @(negedge clk_sys_i);
    irq_ack_i = 1'b1;
    @(negedge clk_sys_i);
    irq_ack_i = 1'b0;
  endtask
  task automatic ret(input logic [6:0] m);
    @(negedge clk_sys_i);
    irq_return_i = 1'b1;
    sw_clr = m;
    @(negedge clk_sys_i);
    irq_return_i = 1'b0;
    sw_clr = 7'h00;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    rd(8'hb7, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(8'ha8, 8'h80 | 8'(1 << i));
      raise(7'(1 << i));
      chk({7'h0, irq_req_o}, 8'h01);
      serve();
      chk(irq_vector_o, rows[i].vec);
      chk(clr, rows[i].clr);
      chk({4'h0, in_service_o}, 8'h01);
      ret(7'(1 << i));
      chk({in_service_o, 3'h0, irq_req_o}, 8'h00);
    end
    wr(8'ha8, 8'hff);
    raise(7'h70);
    serve();
    chk(irq_vector_o, 8'h33);
    ret(7'h70);
    ext0_edge_mode_i = 1'b0;
    wr(8'hb7, 8'h20);
    wr(8'hb8, 8'h20);
    raise(7'h01);
    serve();
    chk(clr, 8'h00);
    raise(7'h02);
    chk({7'h0, irq_req_o}, 8'h00);
    raise(7'h20);
    chk({7'h0, irq_req_o}, 8'h01);
    serve();
    chk(irq_vector_o, 8'h2b);
    chk({4'h0, in_service_o}, 8'h09);
    ret(7'h20);
    chk({in_service_o, 3'h0, irq_req_o}, 8'h10);
    ret(7'h01);
    serve();
    chk(irq_vector_o, 8'h0b);
    ret(7'h00);
    raise(7'h08);
    wr(8'ha8, 8'h7f);
    chk({7'h0, irq_req_o}, 8'h00);
    wr(8'hb7, 8'hff);
    rd(8'hb7, 8'h7f);
    rd(8'hb8, 8'h20);
    rd(8'ha8, 8'h7f);
    chk(rdata_six, 8'h3f);
    rd(8'hb9, 8'h00);
    chk({7'h0, sfr_hit_o}, 8'h00);
    rstn_i = 1'b0;
    #40 rstn_i = 1'b1;
    rd(8'ha8, 8'h00);
    tally_and_finish();
  end
endmodule // four_level_irq_controller_test
bind irq_controller irq_ctrl_props #(.HAS_PCA(HAS_PCA)) i_irq_ctrl_props (.clk_sys_i,
  .rstn_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o, .sfr_hit_o, .ext0_edge_mode_i,
  .ext1_edge_mode_i, .ext0_flag_clear_o, .timer0_flag_clear_o, .ext1_flag_clear_o,
  .timer1_flag_clear_o, .irq_req_o, .irq_vector_o, .irq_ack_i, .irq_return_i, .in_service_o);
`default_nettype wire
